// file: core/stop_reset_pkg.sv
/*
  package for the stop-mode and reset sequencer: clock-source codes, timing
  counts, option and control bit groups, sequencer states.
  assumes a single 200 MHz system clock.
*/
package stop_reset_pkg;

  // system clock period in picoseconds (200 MHz)
  localparam int CLK_PERIOD_PS = 5000;

  // clock-stop time after release, typical, in microseconds
  localparam int STOP_RELEASE_US = 27;
  localparam int STOP_RELEASE_CYC = (STOP_RELEASE_US * 1000000) / CLK_PERIOD_PS;

  // external main clock release: periods of that clock
  localparam logic [4:0] EXT_RELEASE_PERIODS = 5'h18;

  // wait cycles after release, in cpu clocks
  localparam logic [3:0] WAIT_HS_VEC = 4'hb;
  localparam logic [3:0] WAIT_HS_NOVEC = 4'h3;
  localparam logic [3:0] WAIT_XT_VEC = 4'he;
  localparam logic [3:0] WAIT_XT_NOVEC = 4'h6;

  // least external reset pulse, microseconds, and its cycle count
  localparam int EXT_RESET_MIN_US = 10;
  localparam int EXT_RESET_MIN_CYC = (EXT_RESET_MIN_US * 1000000) / CLK_PERIOD_PS;

  // illegal opcode
  localparam logic [7:0] ILLEGAL_OPCODE = 8'hff;

  // reset vector byte locations
  localparam logic [15:0] RESET_VEC_LO = 16'h0000;
  localparam logic [15:0] RESET_VEC_HI = 16'h0001;

  // release counter width
  localparam int RCNT_W = 16;

  // cpu clock source
  typedef enum logic [1:0] {
    SRC_HS_ONCHIP = 2'b00,
    SRC_CRYSTAL = 2'b01,
    SRC_EXT_MAIN = 2'b10
  } clk_src_t;

  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STOP = 3'b001,
    ST_RELEASE = 3'b010,
    ST_WAIT = 3'b011,
    ST_RESET = 3'b100
  } seq_state_t;

  // option-byte and control settings
  typedef struct packed {
    logic wdt_standby_run;
    logic wdt_enable_opt;
    logic lowspeed_osc_keep;
    logic reset_pin_select;
    logic comp_filter_en;
  } opt_t;

  // clock and peripheral enables driven during stop
  typedef struct packed {
    logic cpu_clk_en;
    logic hs_osc_en;
    logic xtal_osc_en;
    logic ext_clk_en;
    logic ls_osc_en;
    logic wdt_run;
    logic mem_en;
    logic interval_tmr_en;
    logic comp_en;
    logic twi_wake_only;
  } pwr_t;

  // reset source pulses
  typedef struct packed {
    logic ext_pin;
    logic wdt_timeout;
    logic select_por;
    logic illegal_op;
    logic retention_lv;
  } rst_src_t;

endpackage

// file: core/stop_reset_ctrl.sv
/*
  stop-mode and reset sequencer: enters stop on the stop instruction, gates
  clocks and memories, releases on an unmasked interrupt or any reset, times
  the release per cpu clock source, and merges five reset sources.
  assumes the cpu core gives one-cycle strobes on the system clock; the reset
  pin and the external clock are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none

// Contract
// (RQ1) stop instruction enters stop state
// (RQ2) pending unmasked interrupt cancels stop at once
// (RQ3) stop gates cpu clock and main oscillators
// (RQ4) low-speed oscillator kept per option bits
// (RQ5) watchdog runs in stop if standby-run set
// (RQ6) port latches hold values through stop
// (RQ7) software stops timers, serial, adc beforehand
// (RQ8) cpu, flash, ram stop; interval timer runs
// (RQ9) comparator runs only without digital filter
// (RQ10) two-wire port offers address-match wakeup only
// (RQ11) unmasked interrupt releases stop, vector or continue
// (RQ12) on-chip clock: 27 us, then 11/3 waits
// (RQ13) crystal: longer of 27 us/settle, 14/6 waits
// (RQ14) external clock: 24 periods, then 11/3 waits
// (RQ15) software may switch to on-chip clock first
// (RQ16) any reset releases stop, restarts at vector
// (RQ17) exactly five reset sources
// (RQ18) reset fetches start address from 0000H/0001H
// (RQ19) opcode FFH resets unless under debug emulator
// (RQ20) external reset needs pin select, 10 us low; code resets on any synchronised low, with no 10 us count
// (RQ21) reset stops all oscillators, ignores external clock
// (RQ22) pin a and reset pin pull states
// (RQ23) clock gated until release count, then wait
module stop_reset_ctrl (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic STOP_EXEC,
  input wire logic OPCODE_VALID,
  input wire logic [7:0] OPCODE,
  input wire logic DEBUG_EMU,
  input wire logic INT_PENDING,
  input wire logic INT_ACK_EN,
  input wire stop_reset_pkg::clk_src_t CLK_SRC,
  input wire stop_reset_pkg::opt_t OPT,
  input wire logic [15:0] OSC_SETTLE_CYC,
  input wire logic RESET_PIN_N,
  input wire logic EXT_CLK_IN,
  input wire logic WDT_TIMEOUT,
  input wire logic SELECT_POR_DET,
  input wire logic RETENTION_LV,
  input wire logic TWI_ADDR_MATCH,
  output stop_reset_pkg::pwr_t PWR,
  output logic IN_STOP,
  output logic PORT_HOLD,
  output logic WAKE_VECTORED,
  output logic WAKE_RESUME,
  output logic SYS_RESET,
  output stop_reset_pkg::rst_src_t RST_SRC,
  output logic [15:0] VEC_ADDR,
  output logic PIN_A_OUT,
  output logic PIN_A_OE,
  output logic PIN_RST_OUT,
  output logic PIN_RST_OE
);

  stop_reset_pkg::seq_state_t state_q, state_d;
  stop_reset_pkg::clk_src_t src_q;
  logic [stop_reset_pkg::RCNT_W-1:0] rcnt_q, rcnt_d;
  logic [4:0] ecnt_q, ecnt_d;
  logic [3:0] wcnt_q, wcnt_d;
  logic vec_q;
  logic [2:0] rpin_sync_q;
  logic [2:0] eclk_sync_q;
  logic rpin_low_q;
  logic eclk_lvl_q;
  logic pwr_gate;
  logic osc_gate;
  logic rel_start;
  logic ext_edge;
  logic wake_req;
  logic stop_now;
  logic illegal_hit;
  logic rst_any;
  logic rel_done;
  logic [3:0] wait_len;
  logic [stop_reset_pkg::RCNT_W-1:0] rel_len;
  logic ls_keep;

  // three-stage synchronisers for the reset pin and external clock
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rpin_sync_q <= 3'h7;
      eclk_sync_q <= 3'h0;
      rpin_low_q <= 1'b0;
      eclk_lvl_q <= 1'b0;
    end else begin
      rpin_sync_q <= {rpin_sync_q[1:0], RESET_PIN_N};
      eclk_sync_q <= {eclk_sync_q[1:0], EXT_CLK_IN};
      // a level change counts only once stages 2 and 3 agree
      if (rpin_sync_q[1] == rpin_sync_q[2]) begin
        rpin_low_q <= !rpin_sync_q[2];
      end
      if (eclk_sync_q[1] == eclk_sync_q[2]) begin
        eclk_lvl_q <= eclk_sync_q[2];
      end
    end
  end

  // external reset only with the pin selected and the filtered pin low
  wire ext_pin_low = OPT.reset_pin_select && rpin_low_q; // RQ20
  // rising edge of the filtered external main clock, one cycle long
  assign ext_edge = eclk_sync_q[1] && eclk_sync_q[2] && !eclk_lvl_q;
  // illegal opcode trap, suppressed under the debug emulator
  assign illegal_hit = OPCODE_VALID && OPCODE == stop_reset_pkg::ILLEGAL_OPCODE
    && !DEBUG_EMU; // RQ19
  // the five reset sources and nothing else
  assign rst_any = ext_pin_low || WDT_TIMEOUT || SELECT_POR_DET || illegal_hit
    || RETENTION_LV; // RQ17
  // unmasked interrupt or two-wire address match wakes the core
  assign wake_req = INT_PENDING || TWI_ADDR_MATCH; // RQ10 RQ11
  // stop taken only when no interrupt is already pending
  assign stop_now = STOP_EXEC && !wake_req; // RQ1 RQ2
  // a pending wake at the stop instruction goes straight to release
  assign rel_start = wake_req && (state_q == stop_reset_pkg::ST_STOP
    || (state_q == stop_reset_pkg::ST_RUN && STOP_EXEC)); // RQ2 RQ11

  // release length: 27 us, or the longer of it and the settle time for crystal
  assign rel_len = (src_q == stop_reset_pkg::SRC_CRYSTAL
    && OSC_SETTLE_CYC > stop_reset_pkg::RCNT_W'(stop_reset_pkg::STOP_RELEASE_CYC))
    ? OSC_SETTLE_CYC : stop_reset_pkg::RCNT_W'(stop_reset_pkg::STOP_RELEASE_CYC); // RQ12 RQ13
  // release ends on the counter, or on 24 external clock periods
  assign rel_done = (src_q == stop_reset_pkg::SRC_EXT_MAIN)
    ? (ecnt_q >= stop_reset_pkg::EXT_RELEASE_PERIODS) : (rcnt_q >= rel_len); // RQ14
  // wait length by source and vectoring; crystal takes the higher figure
  assign wait_len = (src_q == stop_reset_pkg::SRC_CRYSTAL)
    ? (vec_q ? stop_reset_pkg::WAIT_XT_VEC : stop_reset_pkg::WAIT_XT_NOVEC)
    : (vec_q ? stop_reset_pkg::WAIT_HS_VEC : stop_reset_pkg::WAIT_HS_NOVEC); // RQ12 RQ13 RQ14

  // sequencer next state
  always_comb begin
    state_d = state_q;
    rcnt_d = rcnt_q;
    ecnt_d = ecnt_q;
    wcnt_d = wcnt_q;
    case (state_q)
      stop_reset_pkg::ST_RUN: begin
        rcnt_d = stop_reset_pkg::RCNT_W'(1);
        ecnt_d = '0;
        if (stop_now) begin
          state_d = stop_reset_pkg::ST_STOP; // RQ1
        end else if (rel_start) begin
          state_d = stop_reset_pkg::ST_RELEASE; // RQ2
        end
      end
      stop_reset_pkg::ST_STOP: begin
        // the first release cycle counts as one
        rcnt_d = stop_reset_pkg::RCNT_W'(1);
        ecnt_d = '0;
        if (wake_req) begin
          state_d = stop_reset_pkg::ST_RELEASE; // RQ11
        end
      end
      stop_reset_pkg::ST_RELEASE: begin
        rcnt_d = rcnt_q + 1'b1;
        if (ext_edge) begin
          ecnt_d = ecnt_q + 1'b1;
        end
        if (rel_done) begin
          state_d = stop_reset_pkg::ST_WAIT; // RQ23
          wcnt_d = 4'h1;
        end
      end
      stop_reset_pkg::ST_WAIT: begin
        wcnt_d = wcnt_q + 1'b1;
        if (wcnt_q >= wait_len) begin
          state_d = stop_reset_pkg::ST_RUN; // RQ23
        end
      end
      stop_reset_pkg::ST_RESET: begin
        state_d = stop_reset_pkg::ST_RUN; // RQ16 RQ18
      end
      default: begin
        state_d = stop_reset_pkg::ST_RUN;
      end
    endcase
    if (rst_any) begin
      state_d = stop_reset_pkg::ST_RESET; // RQ16
    end
  end

  // state registers; clock source and vectoring latched at entry and release
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= stop_reset_pkg::ST_RESET;
      rcnt_q <= '0;
      ecnt_q <= '0;
      wcnt_q <= '0;
      src_q <= stop_reset_pkg::SRC_HS_ONCHIP;
      vec_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rcnt_q <= rcnt_d;
      ecnt_q <= ecnt_d;
      wcnt_q <= wcnt_d;
      if (state_q == stop_reset_pkg::ST_RUN) begin
        src_q <= CLK_SRC;
      end
      if (rel_start) begin
        vec_q <= INT_ACK_EN && INT_PENDING;
      end
    end
  end

  // power gating follows the next state so outputs line up with it
  assign pwr_gate = state_d == stop_reset_pkg::ST_STOP
    || state_d == stop_reset_pkg::ST_RELEASE; // RQ3 RQ8 RQ23
  // oscillators restart at release so they settle while the cpu clock is held
  assign osc_gate = state_d == stop_reset_pkg::ST_STOP; // RQ3
  // low-speed oscillator keep decision
  assign ls_keep = OPT.lowspeed_osc_keep
    || (OPT.wdt_enable_opt && OPT.wdt_standby_run); // RQ4
  wire in_rst = state_d == stop_reset_pkg::ST_RESET;

  // registered outputs
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PWR <= '0;
      IN_STOP <= 1'b0;
      PORT_HOLD <= 1'b0;
      WAKE_VECTORED <= 1'b0;
      WAKE_RESUME <= 1'b0;
      SYS_RESET <= 1'b1;
      RST_SRC <= '0;
      VEC_ADDR <= stop_reset_pkg::RESET_VEC_LO;
      PIN_A_OUT <= 1'b0;
      PIN_A_OE <= 1'b0;
      PIN_RST_OUT <= 1'b0;
      PIN_RST_OE <= 1'b0;
    end else begin
      PWR.cpu_clk_en <= !pwr_gate && !in_rst; // RQ3 RQ21
      PWR.hs_osc_en <= !osc_gate && !in_rst; // RQ3 RQ21
      PWR.xtal_osc_en <= !osc_gate && !in_rst && src_q == stop_reset_pkg::SRC_CRYSTAL; // RQ3
      PWR.ext_clk_en <= !osc_gate && !in_rst && src_q == stop_reset_pkg::SRC_EXT_MAIN; // RQ21
      PWR.ls_osc_en <= !in_rst && (!pwr_gate || ls_keep); // RQ4 RQ21
      PWR.wdt_run <= !in_rst && OPT.wdt_enable_opt && (!pwr_gate || OPT.wdt_standby_run); // RQ5
      PWR.mem_en <= !pwr_gate && !in_rst; // RQ8
      PWR.interval_tmr_en <= !in_rst; // RQ8
      PWR.comp_en <= !in_rst && (!pwr_gate || !OPT.comp_filter_en); // RQ9
      PWR.twi_wake_only <= pwr_gate; // RQ10
      IN_STOP <= pwr_gate;
      PORT_HOLD <= pwr_gate; // RQ6
      WAKE_VECTORED <= state_q == stop_reset_pkg::ST_WAIT && state_d == stop_reset_pkg::ST_RUN
        && vec_q; // RQ11
      WAKE_RESUME <= state_q == stop_reset_pkg::ST_WAIT && state_d == stop_reset_pkg::ST_RUN
        && !vec_q; // RQ11
      SYS_RESET <= in_rst; // RQ16
      RST_SRC <= {ext_pin_low, WDT_TIMEOUT, SELECT_POR_DET, illegal_hit, RETENTION_LV};
      if (in_rst) begin
        VEC_ADDR <= stop_reset_pkg::RESET_VEC_LO; // RQ18
      end else if (state_q == stop_reset_pkg::ST_RESET) begin
        VEC_ADDR <= stop_reset_pkg::RESET_VEC_HI; // RQ18
      end
      // pin a floats in external or retention reset, else pulled high
      PIN_A_OUT <= 1'b1;
      PIN_A_OE <= !(ext_pin_low || RETENTION_LV); // RQ22
      // reset-shared pin follows the low input in external reset
      PIN_RST_OUT <= !ext_pin_low; // RQ22
      PIN_RST_OE <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: test/stop_reset_chk.sv
/* checker of the stop and reset sequencer ports.
   assumes it is bound onto stop_reset_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module stop_reset_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic STOP_EXEC,
  input wire logic OPCODE_VALID,
  input wire logic [7:0] OPCODE,
  input wire logic DEBUG_EMU,
  input wire logic INT_PENDING,
  input wire logic TWI_ADDR_MATCH,
  input wire stop_reset_pkg::opt_t OPT,
  input wire stop_reset_pkg::pwr_t PWR,
  input wire logic IN_STOP,
  input wire logic PORT_HOLD,
  input wire logic WAKE_VECTORED,
  input wire logic WAKE_RESUME,
  input wire logic SYS_RESET,
  input wire logic [15:0] VEC_ADDR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // running state and the main oscillator group
  wire run = !IN_STOP && !SYS_RESET;
  wire main_osc = PWR.hs_osc_en | PWR.xtal_osc_en | PWR.ext_clk_en;
  wire wake_in = INT_PENDING || TWI_ADDR_MATCH;
  // stop entry and refusal
  stop_entry_a: assert property (
    run && STOP_EXEC && !INT_PENDING && !TWI_ADDR_MATCH |=> IN_STOP) else $error("no stop");
  stop_refuse_a: assert property (
    run && STOP_EXEC && INT_PENDING |=> IN_STOP && PWR.hs_osc_en)
    else $error("pending stop not cleared at once");
  // what stop switches off and keeps
  cpu_gate_a: assert property (IN_STOP |-> !PWR.cpu_clk_en)
    else $error("cpu clock runs in stop");
  osc_off_a: assert property ($rose(IN_STOP) |-> main_osc == $past(wake_in))
    else $error("main oscillator state wrong at stop");
  ls_osc_a: assert property ($rose(IN_STOP) |-> PWR.ls_osc_en ==
    (OPT.lowspeed_osc_keep | OPT.wdt_enable_opt & OPT.wdt_standby_run)) else $error("ls osc");
  peri_stop_a: assert property ($rose(IN_STOP) |-> !PWR.mem_en &&
    PWR.interval_tmr_en && PWR.twi_wake_only && PWR.comp_en != OPT.comp_filter_en &&
    (!OPT.wdt_enable_opt || PWR.wdt_run == OPT.wdt_standby_run)) else $error("peripherals");
  port_hold_a: assert property (IN_STOP |-> PORT_HOLD)
    else $error("ports not held");
  wake_hand_a: assert property ((WAKE_VECTORED || WAKE_RESUME) |-> !IN_STOP &&
    !$past(IN_STOP, 3) && PWR.cpu_clk_en && !(WAKE_VECTORED && WAKE_RESUME))
    else $error("bad hand-back");
  wake_wait_a: assert property ($fell(IN_STOP) && !SYS_RESET |->
    ##[3:14] (WAKE_VECTORED || WAKE_RESUME)) else $error("wait cycles not ended");
  // reset behaviour
  reset_osc_a: assert property ($rose(SYS_RESET) ##1 SYS_RESET |->
    !main_osc && !PWR.ls_osc_en) else $error("oscillator runs in reset");
  trap_a: assert property (run && OPCODE_VALID && OPCODE == 8'hff && !DEBUG_EMU
    |-> ##[1:4] SYS_RESET) else $error("no trap reset");
  vec_lo_a: assert property (SYS_RESET |-> VEC_ADDR == 16'h0000)
    else $error("vector low byte");
endmodule
bind stop_reset_ctrl stop_reset_chk chk (.CLK, .RESETN, .STOP_EXEC, .OPCODE_VALID, .OPCODE,
  .DEBUG_EMU, .INT_PENDING, .TWI_ADDR_MATCH, .OPT, .PWR, .IN_STOP, .PORT_HOLD,
  .WAKE_VECTORED, .WAKE_RESUME, .SYS_RESET, .VEC_ADDR);
`default_nettype wire

// file: test/cpu_model.sv
/* model of the cpu core side: issues stop and opcode strobes one cycle
   after the bench asks. assumes requests change at rising edges. */
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
  input wire logic clk,
  input wire logic stop_req,
  input wire logic op_req,
  input wire logic [7:0] op_code,
  output logic stop_exec = 1'b0,
  output logic op_valid = 1'b0,
  output logic [7:0] opcode = 8'h00
);
  // no timer, serial, adc or buzzer runs here; clock choice is the bench's
  always @(posedge clk) begin
    stop_exec <= stop_req;
    op_valid <= op_req;
    opcode <= op_req ? op_code : ~opcode; // idle bus keeps changing
  end
endmodule
`default_nettype wire

// file: test/stop_reset_ctrl_bench.sv
/* bench of stop_reset_ctrl: stop and wake per clock source, refused stop,
   trap under emulator, five reset causes. assumes cpu_model and checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((e) !== (s)) begin n_mismatch++; \
  $display("mismatch %s exp %0h seen %0h", nm, e, s); end end
module stop_reset_ctrl_bench;
  logic clk = 0, rst_n = 0, stop_req = 0, op_req = 0, emu = 0, intp = 0, ack = 0, twi = 0;
  logic pin_n = 1, ext_clk = 0, wdt = 0, por = 0, lv = 0, stop_exec, op_valid;
  logic in_stop, hold, wv, wr, sys_rst, pa_o, pa_e, pr_o, pr_e;
  logic [7:0] opcode;
  logic [15:0] settle = 16'h0000, vec;
  stop_reset_pkg::clk_src_t src = stop_reset_pkg::SRC_HS_ONCHIP;
  stop_reset_pkg::opt_t opt = '0;
  stop_reset_pkg::pwr_t pwr;
  stop_reset_pkg::rst_src_t rsrc;
  int n_mismatch = 0, checks_done = 0, n, lo;
  // system clock and a free external main clock of unrelated phase
  initial forever #2.5 clk = ~clk;
  initial forever #14.3 ext_clk = ~ext_clk;
  cpu_model cpu (.clk(clk), .stop_req(stop_req), .op_req(op_req), .op_code(8'hff),
    .stop_exec(stop_exec), .op_valid(op_valid), .opcode(opcode));
  stop_reset_ctrl uut (.CLK(clk), .RESETN(rst_n), .STOP_EXEC(stop_exec),
    .OPCODE_VALID(op_valid), .OPCODE(opcode), .DEBUG_EMU(emu), .INT_PENDING(intp),
    .INT_ACK_EN(ack), .CLK_SRC(src), .OPT(opt), .OSC_SETTLE_CYC(settle),
    .RESET_PIN_N(pin_n), .EXT_CLK_IN(ext_clk), .WDT_TIMEOUT(wdt), .SELECT_POR_DET(por),
    .RETENTION_LV(lv), .TWI_ADDR_MATCH(twi), .PWR(pwr), .IN_STOP(in_stop),
    .PORT_HOLD(hold), .WAKE_VECTORED(wv), .WAKE_RESUME(wr), .SYS_RESET(sys_rst),
    .RST_SRC(rsrc), .VEC_ADDR(vec), .PIN_A_OUT(pa_o), .PIN_A_OE(pa_e),
    .PIN_RST_OUT(pr_o), .PIN_RST_OE(pr_e));
  // verdict and end of run
  task automatic end_of_test;
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic sel(int c);
    return c == 0 ? wv | wr : c == 1 ? sys_rst : !sys_rst;
  endfunction
  // count falling edges until the condition holds, bounded
  task automatic wait_on(int c, int lim);
    n = 0;
    do begin
      @(negedge clk) n++;
      if (n > lim) begin
        n_mismatch++;
        end_of_test();
      end
    end while (sel(c) !== 1'b1);
  endtask
  // least release figure: clock-stop time then the wait cycles
  function automatic int wake_lo(stop_reset_pkg::clk_src_t s, logic a, int st);
    int r;
    r = s == stop_reset_pkg::SRC_EXT_MAIN ? 131 : stop_reset_pkg::STOP_RELEASE_CYC;
    if (s == stop_reset_pkg::SRC_CRYSTAL) return (st > r ? st : r) + (a ? 14 : 6);
    return r + (a ? 11 : 3);
  endfunction
  // raise or drop one reset cause
  task automatic drive(int i, logic v);
    case (i)
      0: pin_n <= !v;
      1: wdt <= v;
      2: por <= v;
      3: op_req <= v;
      default: lv <= v;
    endcase
  endtask
  // stop, then wake by interrupt or address match; checks duration and kind of hand-back
  task automatic stop_run(stop_reset_pkg::clk_src_t s, logic a, logic w);
    @(posedge clk);
    src <= s;
    ack <= a;
    opt <= 5'($urandom);
    settle <= 16'($urandom_range(9000, 100));
    stop_req <= 1;
    @(posedge clk) stop_req <= 0;
    repeat (3) @(posedge clk);
    @(negedge clk) `CHK("in_stop", 1'b1, in_stop)
    `CHK("hold", 1'b1, hold)
    @(posedge clk);
    twi <= w;
    intp <= !w;
    lo = wake_lo(s, a, settle);
    wait_on(0, 12000);
    `CHK("wake_time", 1'b1, n >= lo && n <= lo + 16)
    `CHK("vectored", a && !w, wv)
    `CHK("resumed", !(a && !w), wr)
    @(posedge clk);
    intp <= 0;
    twi <= 0;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h5491));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 7; k++) stop_run(stop_reset_pkg::clk_src_t'(k % 3), 1'(k / 3), k == 6);
    // stop with a pending interrupt: no oscillator stop, straight to release
    @(posedge clk) intp <= 1;
    @(posedge clk) stop_req <= 1;
    @(posedge clk) stop_req <= 0;
    repeat (4) @(negedge clk) `CHK("refused", 1'b1, pwr.hs_osc_en)
    lo = wake_lo(src, ack, settle) - 4;
    wait_on(0, 12000);
    `CHK("refused_wake", 1'b1, n >= lo && n <= lo + 16)
    `CHK("refused_kind", ack, wv)
    @(posedge clk);
    intp <= 0;
    emu <= 1;
    op_req <= 1;
    @(posedge clk) op_req <= 0;
    repeat (6) @(negedge clk) `CHK("no_trap", 1'b0, sys_rst)
    @(posedge clk);
    emu <= 0;
    opt.reset_pin_select <= 1;
    stop_req <= 1;
    @(posedge clk) stop_req <= 0;
    repeat (4) @(posedge clk);
    // each cause resets; the first one also ends the stop
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) drive(i, 1);
      @(posedge clk) if (i == 3) drive(3, 0);
      wait_on(1, 20);
      `CHK("stop_exit", 1'b0, in_stop)
      repeat (i ? 3 : 2100) @(posedge clk);
      @(negedge clk) if (i != 3) `CHK("rst_src", 5'h10 >> i, rsrc)
      if (i == 0 || i == 4) `CHK("pin_a_oe", 1'b0, pa_e)
      if (i == 0) `CHK("pin_rst", 1'b0, pr_o)
      @(posedge clk) drive(i, 0);
      wait_on(2, 50);
      `CHK("vec_hi", 16'h0001, vec)
      `CHK("pins_up", 4'hf, {pa_o, pa_e, pr_o, pr_e})
    end
    end_of_test();
  end
endmodule
`default_nettype wire
